// >>> verilog/dio_pkg.sv
// Constants shared by the digital input and output routing block.
// Assumes one 10 MHz system clock.
package dio_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_PERIOD_US = 1000;
  localparam int unsigned SAMPLE_CYCLES =
    (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
  localparam int unsigned F_FAST_HZ = 10_000;
  localparam int unsigned F_PWM_HZ = 2_000;
  localparam int unsigned F_SLOW_HZ = 500;
  localparam int unsigned HOLD_FAST =
    (CLK_HZ + 2 * F_FAST_HZ - 1) / (2 * F_FAST_HZ);
  localparam int unsigned HOLD_PWM =
    (CLK_HZ + 2 * F_PWM_HZ - 1) / (2 * F_PWM_HZ);
  localparam int unsigned HOLD_SLOW =
    (CLK_HZ + 2 * F_SLOW_HZ - 1) / (2 * F_SLOW_HZ);
  localparam int unsigned CNT_W = 14;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses inside the block's window.
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_OUT_CTRL = 8'h00;
  localparam logic [7:0] A_OUT_POL = 8'h04;
  localparam logic [7:0] A_MAN_EN = 8'h08;
  localparam logic [7:0] A_MAN_VAL = 8'h0c;
  localparam logic [7:0] A_CFG_NOFUNC = 8'h10;
  localparam logic [7:0] A_CFG_COMPAT = 8'h14;
  localparam logic [7:0] A_OUT_ROUTE_EN = 8'h18;
  localparam logic [7:0] A_IN_ROUTE_EN = 8'h1c;
  localparam logic [7:0] A_ROUTE_BASE = 8'h20;
  localparam logic [7:0] A_IN_SUMMARY = 8'h40;
  localparam logic [7:0] A_PWM_PERIOD = 8'h44;
  localparam logic [7:0] A_PWM_DUTY = 8'h48;
  localparam logic [7:0] A_INSEL_BASE = 8'h80;

  //////////////////////////////////////////////////////////////////////////
  // Sizes and field positions.
  localparam int unsigned N_PHYS = 16;
  localparam int unsigned N_INSEL = 32;
  localparam int unsigned N_ROUTE = 5;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned LEVEL_LSB = 16;
  localparam int unsigned BRAKE_BIT = 0;
  localparam int unsigned SEL_INV_BIT = 7;
  localparam int unsigned SRC_LSB = 8;

  //////////////////////////////////////////////////////////////////////////
  // Input selector codes, without the inversion bit.
  localparam logic [6:0] IN_ZERO = 7'h00;
  localparam logic [6:0] IN_PHYS_LAST = 7'h10;
  localparam logic [6:0] IN_ENC_A = 7'h44;
  localparam logic [6:0] IN_ENC_B = 7'h45;
  localparam logic [6:0] IN_ENC_I = 7'h46;

  // Output source codes.
  localparam logic [7:0] OS_ONE = 8'h00;
  localparam logic [7:0] OS_ZERO = 8'h01;
  localparam logic [7:0] OS_ENC_FIRST = 8'h02;
  localparam logic [7:0] OS_ENC_LAST = 8'h08;
  localparam logic [7:0] OS_POS_FIRST = 8'h09;
  localparam logic [7:0] OS_POS_LAST = 8'h0f;
  localparam logic [7:0] OS_PWM = 8'h10;
  localparam logic [7:0] OS_PWM_INV = 8'h11;

  //////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0] RST_INSEL = 8'h00;

endpackage

// >>> verilog/dio_div_if.sv
// Connection between the top and a pulse divider.
// Assumes the source level is already in the system clock domain.
`timescale 1ns/1ps
interface dio_div_if;
  logic src;
  logic [dio_pkg::DIV_W-1:0] cnt;
  modport feed(output src, input cnt);
  modport div(input src, output cnt);
endinterface

// >>> verilog/dio_div.sv
// Rising-edge counter whose bits are the source divided by powers of two.
// Assumes a synchronised source level on the interface.
`timescale 1ns/1ps
module dio_div (
  input wire logic hclk,
  input wire logic hresetn,
  dio_div_if.div d
);

  typedef struct packed {
    logic prev;
    logic [dio_pkg::DIV_W-1:0] cnt;
  } dio_div_state_t;

  dio_div_state_t s_r;
  dio_div_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = d.src;
    if (d.src && !s_r.prev) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign d.cnt = s_r.cnt;

endmodule

// >>> verilog/dio_filt.sv
// Sampling filter for the physical inputs.
// Assumes synchronised inputs and a one-cycle sample tick.
`timescale 1ns/1ps
module dio_filt #(
  parameter int unsigned W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] samp;
    logic [W-1:0] q;
  } dio_filt_state_t;

  dio_filt_state_t s_r;
  dio_filt_state_t s_nxt;

  // A level must be seen on two ticks in a row, so a change shorter than
  // one sample period never reaches the summary word.
  always_comb begin
    s_nxt = s_r;
    if (tick) begin
      s_nxt.samp = d;
      for (int i = 0; i < W; i++) begin
        if (d[i] == s_r.samp[i]) begin
          s_nxt.q[i] = d[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule

// >>> verilog/dio_route_top.sv
// Digital input and output routing with an AHB-Lite register slave.
// Assumes one 10 MHz clock; pins and encoder lines are asynchronous.
//
// Overview of operation
// - One input selector per summary bit; selector k drives bit k.
// - Selector 00 gives zero, 01-10 inputs 1-16, 44-46 encoder A, B, index.
// - Selector bit 7 inverts the source; 80 gives one, 81-90 inverted inputs.
// - Selectors C4, C5, C6 give inverted encoder A, B and index.
// - Output n follows control word bit 15+n.
// - Low control bits are special; bit 0 drives the brake.
// - A polarity bit turns a one into a low output level.
// - A manual bit replaces the control bit by the manual value bit.
// - Manual value bits give the level of manual outputs.
// - Configuration words one and five are storage only.
// - Output routing is on while its enable holds one.
// - While routing, polarity and manual settings are ignored.
// - Route entry one drives the PWM pin, entries two to five outputs 1-4.
// - Route entries are 16 bits: high byte source, low byte gate bit.
// - A routed output passes its source only while its gate bit is on.
// - Route bit 7 inverts the gate so that a zero switches on.
// - Source 00 is constant one and source 01 constant zero.
// - Sources 02-08 are encoder pulses divided by 1 to 64.
// - Sources 09-0F are position pulses divided by 1 to 64.
// - Source 10 is the brake PWM and 11 its inverse.
// - Routed outputs are rate limited to 10 kHz, 2 kHz and 500 Hz.
// - Input routing on one uses the selectors.
// - Inputs are sampled each millisecond; shorter pulses are ignored.
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dio_route_top #(
  parameter int unsigned SAMPLE_CYC = dio_pkg::SAMPLE_CYCLES,
  parameter int unsigned SLOW_HOLD = dio_pkg::HOLD_SLOW
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [dio_pkg::N_PHYS-1:0] phys_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic enc_pulse,
  input wire logic pos_pulse,
  output logic pwm_out,
  output logic [dio_pkg::N_ROUTE-2:0] out_pin
);

  localparam int unsigned NR = dio_pkg::N_ROUTE;
  localparam int unsigned NP = dio_pkg::N_PHYS;
  localparam int unsigned RAW_W = NP + 5;
  localparam int unsigned CW = dio_pkg::CNT_W;

  if (SAMPLE_CYC < 2 || SAMPLE_CYC >= (1 << CW)) begin : g_chk_sample
    $error("SAMPLE_CYC out of range");
  end
  if (SLOW_HOLD < 1 || SLOW_HOLD >= (1 << CW)) begin : g_chk_hold
    $error("SLOW_HOLD out of range");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] pol;
    logic [31:0] man_en;
    logic [31:0] man_val;
    logic [31:0] cfg_nofunc;
    logic [31:0] cfg_compat;
    logic out_route_en;
    logic in_route_en;
    logic [NR-1:0][15:0] route;
    logic [dio_pkg::N_INSEL-1:0][7:0] insel;
    logic [15:0] pwm_period;
    logic [15:0] pwm_duty;
    logic [15:0] pwm_cnt;
    logic [31:0] summary;
    logic [NR-1:0][CW-1:0] hold;
    logic [NR-1:0] pin;
    logic [RAW_W-1:0] sync1;
    logic [RAW_W-1:0] sync2;
    logic [CW-1:0] tick_cnt;
    logic tick;
    logic dp_wr;
    logic [dio_pkg::ADDR_W-1:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } dio_top_state_t;

  dio_top_state_t s_r;
  dio_top_state_t s_nxt;
  logic [NP-1:0] phys_q;
  logic [2:0] enc_lvl;

  dio_div_if enc_if ();
  dio_div_if pos_if ();

  //////////////////////////////////////////////////////////////////////////
  // Leaf modules.

  dio_filt #(
    .W(NP)
  ) u_filt (
    .hclk,
    .hresetn,
    .tick(s_r.tick),
    .d(s_r.sync2[NP-1:0]),
    .q(phys_q)
  );

  dio_div u_enc_div (
    .hclk,
    .hresetn,
    .d(enc_if.div)
  );

  dio_div u_pos_div (
    .hclk,
    .hresetn,
    .d(pos_if.div)
  );

  assign enc_if.src = s_r.sync2[NP+3];
  assign pos_if.src = s_r.sync2[NP+4];
  assign enc_lvl = s_r.sync2[NP+2:NP];

  //////////////////////////////////////////////////////////////////////////
  // Helper functions.

  localparam int unsigned DIV_W_L = dio_pkg::DIV_W + 1;

  function automatic logic sel_input(input logic [7:0] code,
      input logic [NP-1:0] phys,
      input logic [2:0] enc);
    logic [6:0] base;
    logic v;
    base = code[6:0];
    v = 1'b0;
    if (base == dio_pkg::IN_ZERO) begin
      v = 1'b0;
    end else if (base <= dio_pkg::IN_PHYS_LAST) begin
      v = phys[4'(base - 7'h01)];
    end else if (base == dio_pkg::IN_ENC_A) begin
      v = enc[0];
    end else if (base == dio_pkg::IN_ENC_B) begin
      v = enc[1];
    end else if (base == dio_pkg::IN_ENC_I) begin
      v = enc[2];
    end else begin
      return 1'b0;
    end
    // Inversion covers C4 to C6 as well as 80 to 90.
    return v ^ code[dio_pkg::SEL_INV_BIT];
  endfunction

  function automatic logic route_val(input logic [15:0] entry,
      input logic [31:0] ctrl,
      input logic [DIV_W_L-1:0] ediv,
      input logic [DIV_W_L-1:0] pdiv,
      input logic pwm);
    logic [7:0] src;
    logic [6:0] idx;
    logic gate;
    logic v;
    src = entry[15:dio_pkg::SRC_LSB];
    idx = entry[6:0];
    gate = (idx < 7'd32) ? ctrl[idx[4:0]] : 1'b0;
    gate = gate ^ entry[dio_pkg::SEL_INV_BIT];
    if (src == dio_pkg::OS_ONE) begin
      v = 1'b1;
    end else if (src == dio_pkg::OS_ZERO) begin
      v = 1'b0;
    end else if (src <= dio_pkg::OS_ENC_LAST) begin
      v = ediv[3'(src - dio_pkg::OS_ENC_FIRST)];
    end else if (src <= dio_pkg::OS_POS_LAST) begin
      v = pdiv[3'(src - dio_pkg::OS_POS_FIRST)];
    end else if (src == dio_pkg::OS_PWM) begin
      v = pwm;
    end else if (src == dio_pkg::OS_PWM_INV) begin
      v = !pwm;
    end else begin
      v = 1'b0;
    end
    return gate & v;
  endfunction

  function automatic logic [CW-1:0] hold_of(input int unsigned i);
    if (i == 0) begin
      return CW'(dio_pkg::HOLD_PWM - 1);
    end else if (i <= 2) begin
      return CW'(dio_pkg::HOLD_FAST - 1);
    end
    return CW'(SLOW_HOLD - 1);
  endfunction

  function automatic logic [31:0] rd(input logic [7:0] a,
      input dio_top_state_t t);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a >= dio_pkg::A_INSEL_BASE) begin
      v = {24'h00_0000, t.insel[a[6:2]]};
    end else if (a >= dio_pkg::A_ROUTE_BASE && a < dio_pkg::A_IN_SUMMARY) begin
      if (a[4:2] < 3'(NR)) begin
        v = {16'h0000, t.route[a[4:2]]};
      end
    end else begin
      unique case (a)
        dio_pkg::A_OUT_CTRL: v = t.ctrl;
        dio_pkg::A_OUT_POL: v = t.pol;
        dio_pkg::A_MAN_EN: v = t.man_en;
        dio_pkg::A_MAN_VAL: v = t.man_val;
        dio_pkg::A_CFG_NOFUNC: v = t.cfg_nofunc;
        dio_pkg::A_CFG_COMPAT: v = t.cfg_compat;
        dio_pkg::A_OUT_ROUTE_EN: v = {31'h0, t.out_route_en};
        dio_pkg::A_IN_ROUTE_EN: v = {31'h0, t.in_route_en};
        dio_pkg::A_IN_SUMMARY: v = t.summary;
        dio_pkg::A_PWM_PERIOD: v = {16'h0000, t.pwm_period};
        dio_pkg::A_PWM_DUTY: v = {16'h0000, t.pwm_duty};
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  logic take;
  logic pwm_lvl;
  logic [DIV_W_L-1:0] ediv;
  logic [DIV_W_L-1:0] pdiv;

  assign take = hsel && hready && htrans[1] && (hsize == 3'b010);
  assign pwm_lvl = s_r.pwm_cnt < s_r.pwm_duty;
  assign ediv = {enc_if.cnt, enc_if.src};
  assign pdiv = {pos_if.cnt, pos_if.src};

  always_comb begin
    logic [4:0] b;
    logic v;
    logic r;
    b = 5'h00;
    v = 1'b0;
    r = 1'b0;
    s_nxt = s_r;
    s_nxt.sync1 = {pos_pulse, enc_pulse, enc_index, enc_b, enc_a, phys_in};
    s_nxt.sync2 = s_r.sync1;

    // Millisecond sample tick.
    if (s_r.tick_cnt == CW'(SAMPLE_CYC - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
      s_nxt.tick = 1'b0;
    end

    // Brake PWM: a period of zero leaves the counter parked at zero.
    if (s_r.pwm_cnt >= s_r.pwm_period) begin
      s_nxt.pwm_cnt = 16'h0000;
    end else begin
      s_nxt.pwm_cnt = s_r.pwm_cnt + 16'h0001;
    end

    // Register writes in the data phase.
    if (s_r.dp_wr) begin
      if (s_r.dp_addr >= dio_pkg::A_INSEL_BASE) begin
        s_nxt.insel[s_r.dp_addr[6:2]] = hwdata[7:0];
      end else if (s_r.dp_addr >= dio_pkg::A_ROUTE_BASE &&
          s_r.dp_addr < dio_pkg::A_IN_SUMMARY) begin
        if (s_r.dp_addr[4:2] < 3'(NR)) begin
          s_nxt.route[s_r.dp_addr[4:2]] = hwdata[15:0];
        end
      end else begin
        unique case (s_r.dp_addr)
          dio_pkg::A_OUT_CTRL: s_nxt.ctrl = hwdata;
          dio_pkg::A_OUT_POL: s_nxt.pol = hwdata;
          dio_pkg::A_MAN_EN: s_nxt.man_en = hwdata;
          dio_pkg::A_MAN_VAL: s_nxt.man_val = hwdata;
          dio_pkg::A_CFG_NOFUNC: s_nxt.cfg_nofunc = hwdata;
          dio_pkg::A_CFG_COMPAT: s_nxt.cfg_compat = hwdata;
          dio_pkg::A_OUT_ROUTE_EN: s_nxt.out_route_en = hwdata == 32'h1;
          dio_pkg::A_IN_ROUTE_EN: s_nxt.in_route_en = hwdata == 32'h1;
          dio_pkg::A_PWM_PERIOD: s_nxt.pwm_period = hwdata[15:0];
          dio_pkg::A_PWM_DUTY: s_nxt.pwm_duty = hwdata[15:0];
          default: s_nxt.ctrl = s_r.ctrl;
        endcase
      end
    end
    s_nxt.dp_wr = take && hwrite;
    s_nxt.dp_addr = haddr[dio_pkg::ADDR_W-1:0];

    // Input summary word.
    if (s_r.in_route_en) begin
      for (int k = 0; k < dio_pkg::N_INSEL; k++) begin
        s_nxt.summary[k] = sel_input(s_r.insel[k], phys_q, enc_lvl);
      end
    end else begin
      s_nxt.summary = {phys_q, 16'h0000};
    end

    // Output pins; index 0 is the PWM pin that carries the brake.
    for (int i = 0; i < NR; i++) begin
      b = (i == 0) ? 5'(dio_pkg::BRAKE_BIT)
          : 5'(dio_pkg::LEVEL_LSB + i - 1);
      v = s_r.man_en[b] ? s_r.man_val[b] : s_r.ctrl[b];
      v = v ^ s_r.pol[b];
      r = route_val(s_r.route[i], s_r.ctrl, ediv, pdiv, pwm_lvl);
      if (s_r.out_route_en) begin
        // Polarity and manual words take no part here.
        if (s_r.hold[i] != '0) begin
          s_nxt.hold[i] = s_r.hold[i] - 1'b1;
        end else if (r != s_r.pin[i]) begin
          s_nxt.pin[i] = r;
          s_nxt.hold[i] = hold_of(i);
        end
      end else begin
        s_nxt.pin[i] = v;
        s_nxt.hold[i] = '0;
      end
    end

    // Read data are formed from the next state so that a read right
    // behind a write returns the new value without a wait state.
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;
    if (take && !hwrite) begin
      s_nxt.hrdata = rd(haddr[dio_pkg::ADDR_W-1:0], s_nxt);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign hrdata = s_r.hrdata;
  assign pwm_out = s_r.pin[0];
  assign out_pin = s_r.pin[NR-1:1];

endmodule

// >>> dv/dio_route_chk.sv
// Port-level checker for the routing block, with register shadows.
// Assumes one master doing word transfers in a window based at 0.
`timescale 1ns/1ps
module dio_route_chk #(
  parameter int unsigned SAMPLE_CYC = 8,
  parameter int unsigned SLOW_HOLD = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [dio_pkg::N_PHYS-1:0] phys_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic enc_pulse,
  input wire logic pos_pulse,
  input wire logic pwm_out,
  input wire logic [dio_pkg::N_ROUTE-2:0] out_pin
);
  //////////////////////////////////////////////////////////////////////////
  logic [31:0] ctl_r, pol_r, men_r, mv_r, eff, erd;
  logic [15:0] rt_r [5];
  logic [15:0] hp_r, h1_r;
  logic [7:0] a_r;
  logic ren_r, wp_r, rp_r, tk, ek;
  logic [4:0] cv, ce;
  int unsigned st_r;
  assign tk = hsel && hready && htrans[1] && hsize == 3'b010;
  assign eff = ((men_r & mv_r) | (~men_r & ctl_r)) ^ pol_r;
  // Brake PWM sources are left out: only constant levels are predicted.
  always_comb begin
    ek = a_r == dio_pkg::A_OUT_CTRL;
    erd = ctl_r;
    for (int i = 0; i < 5; i++) begin
      cv[i] = rt_r[i][15:8] == 8'h00 &&
        ((rt_r[i][6:5] == 2'b00 && ctl_r[rt_r[i][4:0]]) ^ rt_r[i][7]);
      ce[i] = rt_r[i][15:8] < 8'h02 || rt_r[i][15:8] > 8'h11;
      if (a_r == dio_pkg::A_ROUTE_BASE + 8'(4 * i)) begin
        ek = 1'b1;
        erd = {16'h0000, rt_r[i]};
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ctl_r, pol_r, men_r, mv_r} <= '0;
      rt_r <= '{default: '0};
      {ren_r, wp_r, rp_r} <= 3'h0;
      a_r <= 8'h00;
      st_r <= 0;
      hp_r <= 16'hffff;
      h1_r <= 16'hffff;
    end else begin
      wp_r <= tk && hwrite;
      rp_r <= tk && !hwrite;
      a_r <= haddr[7:0];
      if (st_r < 100000) st_r <= st_r + 1;
      hp_r <= !ren_r ? 16'hffff : $changed(pwm_out) ? 16'h0000 :
        hp_r + 16'(hp_r != 16'hffff);
      h1_r <= !ren_r ? 16'hffff : $changed(out_pin[0]) ? 16'h0000 :
        h1_r + 16'(h1_r != 16'hffff);
      if (wp_r) begin
        st_r <= 0;
        case (a_r)
          dio_pkg::A_OUT_CTRL: ctl_r <= hwdata;
          dio_pkg::A_OUT_POL: pol_r <= hwdata;
          dio_pkg::A_MAN_EN: men_r <= hwdata;
          dio_pkg::A_MAN_VAL: mv_r <= hwdata;
          dio_pkg::A_OUT_ROUTE_EN: ren_r <= hwdata == 32'h1;
          default: ;
        endcase
        for (int i = 0; i < 5; i++)
          if (a_r == dio_pkg::A_ROUTE_BASE + 8'(4 * i))
            rt_r[i] <= hwdata[15:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_brake_normal: assert property (
    !ren_r && !$past(ren_r) |-> pwm_out == $past(eff[0]))
    else $error("brake pin differs from its control bit");
  chk_out_normal: assert property (
    !ren_r && !$past(ren_r) |-> out_pin == $past(eff[19:16]))
    else $error("output pins differ from their level bits");
  chk_pwm_const: assert property (
    ren_r && st_r > 2600 && ce[0] |-> pwm_out == cv[0])
    else $error("routed pwm pin wrong");
  chk_out_const: assert property (
    ren_r && st_r > 2600 + SLOW_HOLD |->
    ((out_pin ^ cv[4:1]) & ce[4:1]) == 4'h0)
    else $error("routed output pin wrong");
  chk_read_back: assert property (
    rp_r && ek |-> hrdata == erd)
    else $error("read data differs from last write");
  chk_pwm_rate: assert property (
    ren_r && $past(ren_r) && $changed(pwm_out) |-> hp_r >= 16'd2499)
    else $error("pwm pin changed too soon");
  chk_out1_rate: assert property (
    ren_r && $past(ren_r) && $changed(out_pin[0]) |-> h1_r >= 16'd499)
    else $error("output 1 changed too soon");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
endmodule

bind dio_route_top dio_route_chk #(.SAMPLE_CYC(SAMPLE_CYC),
  .SLOW_HOLD(SLOW_HOLD)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .phys_in, .enc_a, .enc_b, .enc_index, .enc_pulse, .pos_pulse,
  .pwm_out, .out_pin);

// >>> dv/dio_pins_model.sv
// Pin-side model: physical inputs, encoder lines and pulse sources.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module dio_pins_model (
  input wire logic hclk,
  output logic [15:0] phys_in,
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic enc_pulse,
  output logic pos_pulse
);
  initial begin
    phys_in = 16'h0000;
    {enc_a, enc_b, enc_index, enc_pulse, pos_pulse} = 5'h00;
  end
  task automatic set_lvl(input logic [15:0] p, input logic [2:0] e);
    @(posedge hclk);
    phys_in <= p;
    {enc_index, enc_b, enc_a} <= e;
  endtask
  // A two-cycle flip is far shorter than the sample period.
  task automatic glitch();
    @(posedge hclk);
    phys_in <= ~phys_in;
    repeat (2) @(posedge hclk);
    phys_in <= ~phys_in;
  endtask
  // Halves of 550 cycles outlast the fast output hold time.
  task automatic pulses(input int n, input logic pos);
    for (int i = 0; i < 2 * n; i++) begin
      if (pos) pos_pulse <= !pos_pulse;
      else enc_pulse <= !enc_pulse;
      repeat (550) @(posedge hclk);
    end
  endtask
endmodule

// >>> dv/dio_route_top_tb.sv
// Self-checking bench for the routing block with a pin-side model.
// Assumes the block window starts at address 0 and a single master.
`timescale 1ns/1ps
module dio_route_top_tb;
  localparam int unsigned SCYC = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, ctl, pol, men, mv, ex, pv;
  logic hready, hreadyout, hresp, pwm_out, o1_q;
  logic [3:0] out_pin;
  logic [15:0] phys_in, ph;
  logic [15:0] rt [5];
  logic [2:0] en;
  logic [7:0] s8;
  logic enc_a, enc_b, enc_index, enc_pulse, pos_pulse;
  logic [7:0] base [16] = '{8'h00, 8'h01, 8'h07, 8'h10, 8'h44, 8'h45,
    8'h46, 8'h20, 8'h08, 8'h02, 8'h0f, 8'h03, 8'h44, 8'h46, 8'h11, 8'h7f};
  logic [7:0] srcs [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h20, 8'h00,
    8'h01, 8'hff};
  int bad_count = 0;
  int checks_done = 0;
  int seed = 64437;
  int rises = 0;
  int r0;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  assign pv = {27'h0, out_pin, pwm_out};
  always @(posedge hclk) begin
    if (out_pin[0] === 1'b1 && o1_q === 1'b0) rises++;
    o1_q <= out_pin[0];
  end
  dio_route_top #(.SAMPLE_CYC(SCYC), .SLOW_HOLD(4)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .phys_in, .enc_a, .enc_b,
    .enc_index, .enc_pulse, .pos_pulse, .pwm_out, .out_pin);
  dio_pins_model u_pins (.hclk, .phys_in, .enc_a, .enc_b, .enc_index,
    .enc_pulse, .pos_pulse);
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sel(input int k);
    return k < 16 ? base[k] : base[k - 16] | 8'h80;
  endfunction
  function automatic logic in_bit(input logic [7:0] c);
    logic [6:0] s;
    s = c[6:0];
    if (s == 7'h00) return c[7];
    if (s >= 7'h01 && s <= 7'h10) return ph[s - 7'h01] ^ c[7];
    if (s >= 7'h44 && s <= 7'h46) return en[s - 7'h44] ^ c[7];
    return 1'b0;
  endfunction
  function automatic logic route_pin(input logic [15:0] r);
    logic g;
    g = (r[6:5] == 2'b00 ? ctl[r[4:0]] : 1'b0) ^ r[7];
    return (r[15:8] == 8'h00 || r[15:8] == 8'h11) && g;
  endfunction
  function automatic logic [31:0] pins();
    logic [31:0] e;
    e = ((men & mv) | (~men & ctl)) ^ pol;
    return {27'h0, e[19:16], e[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One word transfer; each phase waits up to 20 cycles.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int wt;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    for (int p = 0; p < 2; p++) begin
      wt = 0;
      do begin
        @(posedge hclk);
        wt++;
      end while (hready !== 1'b1 && wt < 20);
      if (hready !== 1'b1) begin
        bad_count++;
        print_verdict();
      end
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
      end
    end
    rd = hrdata;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      bus(0, dio_pkg::A_ROUTE_BASE + 8'(4 * i), 0);
      check("route reset", rd, 0);
    end
    bus(0, 8'h4c, 0);
    check("unmapped read", rd, 0);
    for (int i = 0; i < 8; i++) begin
      ctl = $random(seed);
      pol = $random(seed);
      men = $random(seed);
      mv = $random(seed);
      bus(1, dio_pkg::A_OUT_CTRL, ctl);
      bus(1, dio_pkg::A_OUT_POL, pol);
      bus(1, dio_pkg::A_MAN_EN, men);
      bus(1, dio_pkg::A_MAN_VAL, mv);
      repeat (3) @(posedge hclk);
      check("normal pins", pv, pins());
    end
    ex = $random(seed);
    bus(1, dio_pkg::A_CFG_NOFUNC, ~ex);
    bus(1, dio_pkg::A_CFG_COMPAT, ex);
    bus(0, dio_pkg::A_CFG_COMPAT, 0);
    check("compat entry", rd, ex);
    check("pins kept", pv, pins());
    for (int i = 0; i < 4; i++) begin
      ph = $random(seed);
      en = $random(seed);
      u_pins.set_lvl(ph, en);
      if (i == 2) begin
        for (int k = 0; k < 32; k++)
          bus(1, dio_pkg::A_INSEL_BASE + 8'(4 * k), {24'h0, sel(k)});
        bus(1, dio_pkg::A_IN_ROUTE_EN, 1);
      end
      repeat (5 * SCYC) @(posedge hclk);
      u_pins.glitch();
      repeat (5 * SCYC) @(posedge hclk);
      ex = {ph, 16'h0000};
      if (i >= 2) for (int k = 0; k < 32; k++) ex[k] = in_bit(sel(k));
      bus(0, dio_pkg::A_IN_SUMMARY, 0);
      check("input summary", rd, ex);
    end
    bus(1, dio_pkg::A_PWM_PERIOD, 32'h10);
    bus(1, dio_pkg::A_PWM_DUTY, 0);
    bus(1, dio_pkg::A_OUT_ROUTE_EN, 1);
    for (int i = 0; i < 6; i++) begin
      ctl = $random(seed);
      bus(1, dio_pkg::A_OUT_CTRL, ctl);
      for (int j = 0; j < 5; j++) begin
        s8 = $random(seed);
        rt[j] = {srcs[(i + j) % 8], i == 0 ? s8 : s8 & 8'h9f};
        bus(1, dio_pkg::A_ROUTE_BASE + 8'(4 * j), {16'h0, rt[j]});
        bus(0, dio_pkg::A_ROUTE_BASE + 8'(4 * j), 0);
        check("route entry", rd, {16'h0, rt[j]});
      end
      repeat (2700) @(posedge hclk);
      ex = 0;
      for (int j = 0; j < 5; j++) ex[j] = route_pin(rt[j]);
      check("routed pins", pv, ex);
    end
    for (int i = 0; i < 6; i++) begin
      s8 = i < 3 ? 8'h02 + 8'(i) : 8'h06 + 8'(i);
      bus(1, dio_pkg::A_OUT_CTRL, 0);
      bus(1, dio_pkg::A_ROUTE_BASE + 8'h04, {16'h0, s8, 8'h05});
      repeat (600) @(posedge hclk);
      bus(1, dio_pkg::A_OUT_CTRL, 32'h20);
      repeat (600) @(posedge hclk);
      r0 = rises;
      u_pins.pulses(4, i >= 3);
      repeat (600) @(posedge hclk);
      check("divided rises", rises - r0, 4 >> (i % 3));
    end
    ctl = 32'h20;
    bus(1, dio_pkg::A_OUT_ROUTE_EN, 32'h3);
    repeat (3) @(posedge hclk);
    check("pins unrouted", pv, pins());
    print_verdict();
  end
endmodule
